// File: core/rpsa_pkg.sv
// package of constants for the rail phase slot assignment block
package rpsa_pkg;
    // ======================================================
    // register map
    localparam logic [7:0]  CMD_RAIL_PHASE_CONFIG = 8'hd3;
    localparam int          CFG_WIDTH             = 16;
    // ======================================================
    // field positions
    localparam int          SLOT_MSB              = 15;
    localparam int          SLOT_LSB              = 13;
    localparam int          GROUP_MSB             = 12;
    localparam int          GROUP_LSB             = 8;
    localparam int          COUNT_MSB             = 2;
    localparam int          COUNT_LSB             = 0;
    localparam logic [15:0] CFG_WRITE_MASK        = 16'hff07;
    localparam logic [15:0] CFG_RESET_BASE        = 16'h0000;
    // ======================================================
    // phase count codes (count minus one)
    localparam logic [2:0]  COUNT_TWO             = 3'h1;
    localparam logic [2:0]  COUNT_FOUR            = 3'h3;
    localparam logic [2:0]  COUNT_SIX             = 3'h5;
    localparam logic [2:0]  COUNT_EIGHT           = 3'h7;
    localparam logic [2:0]  MAX_SLOT_INDEX        = 3'h3;
    // ======================================================
    // positions, eighths of the switching period (45 degrees each)
    localparam logic [2:0]  POS_HALF_PERIOD       = 3'h4;
    localparam logic [2:0]  POS_STEP_FOUR         = 3'h2;
    localparam logic [7:0]  DEG_PER_POS           = 8'h2d;
    localparam logic [9:0]  POS_PERIOD_SHIFT      = 10'h003;
    typedef enum logic [1:0] {
        RPSA_MODE_SPREAD,
        RPSA_MODE_SHARED,
        RPSA_MODE_INVALID
    } rpsa_mode_t;
endpackage

// File: core/rpsa_slot_map.sv
// phase position decoder from the rail configuration fields
`timescale 1ns/1ps
`default_nettype none
module rpsa_slot_map (
    input  wire logic [2:0] phase_count_code,
    input  wire logic [2:0] slot_index,
    input  wire logic [2:0] phase_spread_setting,
    output logic            shared,
    output logic            legal,
    output logic [2:0]      pos_a,
    output logic [2:0]      pos_b
);
    // ======================================================
    // decode
    always_comb begin
        shared = 1'b0;
        legal  = 1'b1;
        pos_a  = 3'h0;
        unique case (phase_count_code)
            rpsa_pkg::COUNT_TWO: begin
                // standalone: spread setting governs first channel
                pos_a = phase_spread_setting;
            end
            rpsa_pkg::COUNT_FOUR: begin
                shared = 1'b1;
                legal  = (slot_index <= 3'h1);
                pos_a  = slot_index[0] ? rpsa_pkg::POS_STEP_FOUR : 3'h0;
            end
            rpsa_pkg::COUNT_SIX: begin
                shared = 1'b1;
                legal  = (slot_index <= 3'h2);
                pos_a  = slot_index;
            end
            rpsa_pkg::COUNT_EIGHT: begin
                shared = 1'b1;
                legal  = (slot_index <= rpsa_pkg::MAX_SLOT_INDEX);
                pos_a  = slot_index;
            end
            default: begin
                legal = 1'b0;
                pos_a = phase_spread_setting;
            end
        endcase
        // second channel half a period later, wraps modulo eight
        pos_b = pos_a + rpsa_pkg::POS_HALF_PERIOD;
    end
endmodule
`default_nettype wire

// File: core/rpsa_top.sv
// rail configuration word and channel phase slot assignment
`timescale 1ns/1ps
`default_nettype none
module rpsa_top (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [4:0]  strap_addr,
    input  wire logic        write_protect,
    input  wire logic        cmd_write,
    input  wire logic        cmd_read,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic [2:0]  phase_spread_setting,
    input  wire logic [9:0]  period_cycles,
    input  wire logic        period_start,
    output logic [15:0]      cmd_rdata,
    output logic             cmd_ack,
    output logic             cmd_nak,
    output logic             shared_rail,
    output logic             config_legal,
    output logic [2:0]       chan0_pos,
    output logic [2:0]       chan1_pos,
    output logic [8:0]       chan0_deg,
    output logic [8:0]       chan1_deg,
    output logic             chan0_start,
    output logic             chan1_start
);
    // ======================================================
    // strap capture
    logic [4:0]  strap_s1;
    logic [4:0]  strap_s2;
    logic        wp_s1;
    logic        wp_s2;
    logic        strap_seen;
    logic [15:0] cfg;
    logic        hit;
    logic        m_shared;
    logic        m_legal;
    logic [2:0]  m_pos_a;
    logic [2:0]  m_pos_b;
    logic [9:0]  phase_cnt;
    logic [9:0]  delay_a;
    logic [9:0]  delay_b;
    logic        hold_a;
    logic        hold_b;

    // converts a position to degrees, 45 per step
    function automatic logic [8:0] pos_to_deg(input logic [2:0] p);
        pos_to_deg = 9'(p) * 9'(rpsa_pkg::DEG_PER_POS);
    endfunction

    // converts a position to a delay in cycles, eighths of period
    function automatic logic [9:0] pos_to_delay(input logic [2:0] p, input logic [9:0] per);
        logic [12:0] prod;
        prod = 13'(per) * 13'(p);
        pos_to_delay = prod[12:3];
    endfunction

    always_ff @(posedge ref_clk) begin
        strap_s1 <= strap_addr;
        strap_s2 <= strap_s1;
        wp_s1    <= write_protect;
        wp_s2    <= wp_s1;
    end

    // ======================================================
    // rail configuration word
    assign hit = (cmd_code == rpsa_pkg::CMD_RAIL_PHASE_CONFIG);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cfg        <= rpsa_pkg::CFG_RESET_BASE;
            strap_seen <= 1'b0;
        end else if (!strap_seen) begin
            // group taken from the synchronised strap after release
            cfg <= rpsa_pkg::CFG_RESET_BASE;
            cfg[rpsa_pkg::GROUP_MSB:rpsa_pkg::GROUP_LSB] <= strap_s2;
            strap_seen <= 1'b1;
        end else if (cmd_write && hit && !wp_s2) begin
            cfg <= cmd_wdata & rpsa_pkg::CFG_WRITE_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cmd_rdata <= 16'h0000;
            cmd_ack   <= 1'b0;
            cmd_nak   <= 1'b0;
        end else begin
            cmd_ack   <= (cmd_write || cmd_read) && hit && !(cmd_write && wp_s2);
            cmd_nak   <= (cmd_write || cmd_read) && (!hit || (cmd_write && wp_s2));
            cmd_rdata <= (cmd_read && hit) ? cfg : 16'h0000;
        end
    end

    // ======================================================
    // slot decode
    rpsa_slot_map u_map (
        .phase_count_code     (cfg[rpsa_pkg::COUNT_MSB:rpsa_pkg::COUNT_LSB]),
        .slot_index           (cfg[rpsa_pkg::SLOT_MSB:rpsa_pkg::SLOT_LSB]),
        .phase_spread_setting (phase_spread_setting),
        .shared               (m_shared),
        .legal                (m_legal),
        .pos_a                (m_pos_a),
        .pos_b                (m_pos_b)
    );

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            shared_rail  <= 1'b0;
            config_legal <= 1'b0;
            chan0_pos    <= 3'h0;
            chan1_pos    <= rpsa_pkg::POS_HALF_PERIOD;
            chan0_deg    <= 9'h000;
            chan1_deg    <= 9'h0b4;
        end else begin
            shared_rail  <= m_shared;
            config_legal <= m_legal;
            chan0_pos    <= m_pos_a;
            chan1_pos    <= m_pos_b;
            chan0_deg    <= pos_to_deg(m_pos_a);
            chan1_deg    <= pos_to_deg(m_pos_b);
        end
    end

    // ======================================================
    // per channel cycle start, delayed from the period start
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            phase_cnt <= 10'h000;
            delay_a   <= 10'h000;
            delay_b   <= 10'h000;
        end else begin
            phase_cnt <= period_start ? 10'h000 : phase_cnt + 10'h001;
            delay_a   <= pos_to_delay(chan0_pos, period_cycles);
            delay_b   <= pos_to_delay(chan1_pos, period_cycles);
        end
    end

    assign hold_a = (phase_cnt == delay_a);
    assign hold_b = (phase_cnt == delay_b);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            chan0_start <= 1'b0;
            chan1_start <= 1'b0;
        end else begin
            chan0_start <= hold_a && !period_start && config_legal;
            chan1_start <= hold_b && !period_start && config_legal;
        end
    end

    // ======================================================
    // checks
    sequence s_write_cfg;
        cmd_write && hit && !wp_s2 && strap_seen;
    endsequence

    cfg_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_write_cfg |=> cfg == ($past(cmd_wdata) & rpsa_pkg::CFG_WRITE_MASK))
        else $error("config write not stored");
    wp_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (strap_seen && wp_s2) |=> $stable(cfg))
        else $error("protected word changed");
    strap_load_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (nrst && !strap_seen) |=> cfg == {3'h0, $past(strap_s2), 8'h00})
        else $error("reset group not from strap");
    two_phase_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cfg[2:0] == rpsa_pkg::COUNT_TWO && phase_spread_setting == 3'h0) |=>
        chan0_pos == 3'h0 && chan1_pos == 3'h4)
        else $error("standalone positions wrong");
    four_phase_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cfg[2:0] == rpsa_pkg::COUNT_FOUR && cfg[15:13] == 3'h1) |=>
        chan0_pos == 3'h2 && chan1_pos == 3'h6)
        else $error("four phase positions wrong");
    multi_phase_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cfg[2:0] == rpsa_pkg::COUNT_EIGHT) |=>
        chan0_pos == $past(cfg[15:13]) && chan1_pos == 3'($past(cfg[15:13]) + 3'h4))
        else $error("multi phase positions wrong");
    shared_spread_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cfg[2:0] == rpsa_pkg::COUNT_SIX && $stable(cfg)) |=> $stable(chan0_pos))
        else $error("spread setting leaked into shared rail");
    start_delay_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        chan0_start |-> $past(phase_cnt) == $past(delay_a))
        else $error("channel start off its slot");

    // ======================================================
    // reset and command checks
    sequence s_blocked_write;
        cmd_write && hit && wp_s2 && strap_seen;
    endsequence

    // no disable here, so the cleared state itself is looked at
    reset_clear_a: assert property (@(posedge ref_clk)
        !nrst |=> cfg == rpsa_pkg::CFG_RESET_BASE && !cmd_ack && !cmd_nak &&
        !chan0_start && !chan1_start && chan1_pos == rpsa_pkg::POS_HALF_PERIOD)
        else $error("reset state not cleared");

    strap_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        strap_seen |=> strap_seen)
        else $error("strap load repeated");

    wp_sync_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        wp_s2 == $past(write_protect, 2))
        else $error("write protect not two flops deep");

    wp_nak_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_blocked_write |=> cmd_nak && !cmd_ack && $stable(cfg))
        else $error("protected write not refused");

    write_ack_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cmd_write && hit && !wp_s2) |=> cmd_ack && !cmd_nak)
        else $error("open write not acknowledged");

    slot_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (strap_seen && !(cmd_write && hit)) |=> $stable(cfg))
        else $error("word changed without a write");

    read_data_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cmd_read && !cmd_write && hit) |=> cmd_ack && cmd_rdata == $past(cfg))
        else $error("read data not the stored word");

    rdata_idle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !(cmd_read && hit) |=> cmd_rdata == 16'h0000)
        else $error("read data shown without a read");

    bad_code_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ((cmd_write || cmd_read) && !hit) |=> cmd_nak && !cmd_ack)
        else $error("unknown command not refused");

    ack_excl_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !(cmd_ack && cmd_nak))
        else $error("ack and nak together");

    reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        cfg[7:3] == 5'h00)
        else $error("reserved bits set");

    // ======================================================
    // decode checks
    shared_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cfg[0] && cfg[2:0] != rpsa_pkg::COUNT_TWO) |=> shared_rail)
        else $error("shared rail flag missing");

    standalone_spread_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cfg[2:0] == rpsa_pkg::COUNT_TWO) |=>
        !shared_rail && chan0_pos == $past(phase_spread_setting))
        else $error("standalone rail ignores spread setting");

    legal_two_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cfg[2:0] == rpsa_pkg::COUNT_TWO) |=> config_legal)
        else $error("standalone rail flagged illegal");

    even_code_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !cfg[0] |=> !config_legal && !shared_rail)
        else $error("even count code accepted");

    four_index_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cfg[2:0] == rpsa_pkg::COUNT_FOUR && cfg[15:13] > 3'h1) |=> !config_legal)
        else $error("four phase index out of range accepted");

    six_index_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cfg[2:0] == rpsa_pkg::COUNT_SIX && cfg[15:13] > 3'h2) |=> !config_legal)
        else $error("six phase index out of range accepted");

    eight_index_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cfg[2:0] == rpsa_pkg::COUNT_EIGHT && cfg[15:13] > rpsa_pkg::MAX_SLOT_INDEX) |=>
        !config_legal)
        else $error("eight phase index out of range accepted");

    pair_offset_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        chan1_pos == 3'(chan0_pos + rpsa_pkg::POS_HALF_PERIOD))
        else $error("second channel not half a period later");

    // the degree scale must not wrap for positions six and seven
    deg_scale_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        chan0_deg == 9'(chan0_pos) * 9'(rpsa_pkg::DEG_PER_POS) &&
        chan1_deg == 9'(chan1_pos) * 9'(rpsa_pkg::DEG_PER_POS))
        else $error("degrees not 45 per position");

    // ======================================================
    // start timing checks
    sequence s_period_begin;
        period_start ##1 (!period_start && config_legal);
    endsequence

    cnt_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        period_start |=> phase_cnt == 10'h000)
        else $error("period start did not clear count");

    start_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !config_legal |=> !chan0_start && !chan1_start)
        else $error("start pulse from illegal setting");

    slot0_start_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_period_begin ##0 delay_a == 10'h000) |=> chan0_start)
        else $error("first channel missed slot zero");
endmodule
`default_nettype wire

// File: sim/rpsa_host_model.sv
// host model issuing rail configuration commands
`timescale 1ns/1ps
`default_nettype none
module rpsa_host_model (
    input  wire logic        ref_clk,
    input  wire logic        cmd_ack,
    input  wire logic        cmd_nak,
    input  wire logic [15:0] cmd_rdata,
    output logic             cmd_write,
    output logic             cmd_read,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata
);
    // ======================================
    // request pulse, then bounded wait for ack or nak
    initial begin
        cmd_write = 1'b0;
        cmd_read  = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                        output logic [1:0] resp, output logic [15:0] rd);
        resp = 2'h0;
        rd = 16'h0000;
        @(posedge ref_clk);
        cmd_write <= wr;
        cmd_read  <= ~wr;
        cmd_code  <= code;
        cmd_wdata <= wd;
        @(posedge ref_clk);
        cmd_write <= 1'b0;
        cmd_read  <= 1'b0;
        // released lines carry no stale value
        cmd_code  <= ~code;
        cmd_wdata <= ~wd;
        for (int i = 0; i < 3 && resp == 2'h0; i++) begin
            #1;
            if (cmd_ack === 1'b1) begin
                resp = 2'h1;
                rd = cmd_rdata;
            end else if (cmd_nak === 1'b1) begin
                resp = 2'h2;
            end else begin
                @(posedge ref_clk);
            end
        end
    endtask
endmodule
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for the rail phase slot assignment block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [7:0] CMD = rpsa_pkg::CMD_RAIL_PHASE_CONFIG;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [4:0]  strap_addr = 5'h16;
    logic        write_protect = 1'b0;
    logic [2:0]  phase_spread_setting = 3'h0;
    logic [9:0]  period_cycles = 10'h050;
    logic        period_start = 1'b0;
    logic        cmd_write, cmd_read, cmd_ack, cmd_nak, shared_rail, config_legal;
    logic        chan0_start, chan1_start;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, rd, cfg;
    logic [2:0]  chan0_pos, chan1_pos;
    logic [8:0]  chan0_deg, chan1_deg;
    logic [1:0]  resp;
    logic [31:0] seed = 32'h3139;
    int          fail_count = 0;
    int          checked = 0;
    int          t0, t1, base;
    always #5 ref_clk = ~ref_clk;
    rpsa_top dut (.ref_clk, .nrst, .strap_addr, .write_protect, .cmd_write, .cmd_read,
        .cmd_code, .cmd_wdata, .phase_spread_setting, .period_cycles, .period_start,
        .cmd_rdata, .cmd_ack, .cmd_nak, .shared_rail, .config_legal, .chan0_pos,
        .chan1_pos, .chan0_deg, .chan1_deg, .chan0_start, .chan1_start);
    rpsa_host_model host (.ref_clk, .cmd_ack, .cmd_nak, .cmd_rdata, .cmd_write,
        .cmd_read, .cmd_code, .cmd_wdata);
    // ======================================
    // expectations
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [2:0] exp_pos0(logic [15:0] c, logic [2:0] sp);
        case (c[2:0])
            3'h3: return 3'(c[15:13] << 1);
            3'h5, 3'h7: return c[15:13];
            default: return sp;
        endcase
    endfunction
    function automatic logic exp_legal(logic [15:0] c);
        return c[0] && (c[15:13] <= {1'b0, c[2:1]});
    endfunction
    // ======================================
    // compare, configure, measure, close
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic apply(input logic [15:0] c);
        logic [2:0] p;
        host.xfer(1'b1, CMD, c, resp, rd);
        chk(resp, 2'h1);
        if (resp === 2'h0) finish_test();
        repeat (2) @(posedge ref_clk);
        #1;
        p = exp_pos0(c, phase_spread_setting);
        chk(shared_rail, c[0] && c[2:0] != 3'h1);
        chk(config_legal, exp_legal(c));
        if (exp_legal(c) || !c[0]) begin
            chk(chan0_pos, p);
            chk(chan1_pos, 3'(p + 3'h4));
            chk(chan0_deg, p * 9'd45);
            chk(chan1_deg, 3'(p + 3'h4) * 9'd45);
        end
        host.xfer(1'b0, CMD, 16'h0000, resp, rd);
        chk(rd, c & rpsa_pkg::CFG_WRITE_MASK);
    endtask
    task automatic measure(output int a, output int b);
        a = -1;
        b = -1;
        @(posedge ref_clk);
        period_start <= 1'b1;
        @(posedge ref_clk);
        period_start <= 1'b0;
        for (int i = 0; i < 300 && (a < 0 || b < 0); i++) begin
            @(posedge ref_clk);
            #1;
            if (chan0_start === 1'b1 && a < 0) a = i;
            if (chan1_start === 1'b1 && b < 0) b = i;
        end
        if (a < 0 || b < 0) begin
            fail_count++;
            finish_test();
        end
    endtask
    // ======================================
    // main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        host.xfer(1'b0, CMD, 16'h0000, resp, rd);
        chk(rd, {3'h0, strap_addr, 8'h00});
        apply(16'h0001);
        measure(base, t1);
        chk(t1 - base, 40);
        phase_spread_setting <= 3'h3;
        for (int c = 3; c <= 7; c += 2) begin
            for (int k = 0; k <= c / 2; k++) begin
                cfg = {3'(k), strap_addr, 5'h00, 3'(c)};
                apply(cfg);
                measure(t0, t1);
                chk(t0 - base, 10 * exp_pos0(cfg, 3'h0));
                chk(t1 - t0, 40);
            end
        end
        apply(16'hffff);
        write_protect <= 1'b1;
        repeat (3) @(posedge ref_clk);
        host.xfer(1'b1, CMD, 16'h2103, resp, rd);
        chk(resp, 2'h2);
        host.xfer(1'b0, CMD, 16'h0000, resp, rd);
        chk(rd, 16'hff07);
        write_protect <= 1'b0;
        host.xfer(1'b1, 8'hd4, 16'h2103, resp, rd);
        chk(resp, 2'h2);
        for (int n = 0; n < 30; n++) begin
            cfg = 16'(xorshift());
            if (cfg[2:0] == 3'h1) cfg[15:13] = 3'h0;
            @(posedge ref_clk);
            phase_spread_setting <= 3'(seed >> 20);
            apply(cfg);
        end
        // second reset mid-run, strap moved
        @(posedge ref_clk);
        strap_addr <= 5'h0b;
        nrst       <= 1'b0;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        host.xfer(1'b0, CMD, 16'h0000, resp, rd);
        chk(rd, {3'h0, 5'h0b, 8'h00});
        chk(config_legal, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
